// ==== design/request_router.sv ====
// Request port router: picks the serial port for each incoming request
// Assumes requests arrive one beat per cycle on clk from upstream logic
//
// Behaviour
// - Per-port parity none/odd/even/space/mark and one or two stop bits.
// - Per-port bit rate from 50 up to 961200 bps.
// - Per-port flow control: none, RTS/CTS (RTS held high; CTS does not hold back out_valid), or RTS toggle.
// - RTS toggle, with rs232 set, raises RTS for on-delay after the request is sent; out_valid does not wait for tx_go.
// - After last bit, wait off-delay, then drop RTS.
// - Slave-ID routing sends a request only to its mapped port.
// - Default table: IDs 1-5 to port one, 6-10 to port two.
// - Auto routing with cleared table learns each ID's port.
// - Auto routing keeps learning devices attached later.
// - Same ID seen on two ports is marked conflict and reported, unless its entry is a user entry.
// - Kept user entries are obeyed; learning only fills absent IDs.
// - Signed entry offset added to virtual ID gives the real ID.
// - Requests on an assigned TCP port go to its serial port.
// - Requests to an assigned IP go to its serial port.
// - Port routing lets at most four masters share one port.
// - Full 32-deep queue, or unknown ID under slave-ID routing, drops the request.
`timescale 1ns/10ps
`include "router_consts.svh"
module request_router
    import router_pkg::*;
#(
    parameter int PORTS     = 4,
    parameter int IDS       = 256,
    parameter int MS_CYCLES = `RTS_MS_CYCLES
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset_n,
    // Register port
    input  wire logic [7:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic [31:0]            reg_rdata,
    // Request stream in
    input  wire request_type       req,
    input  wire logic              req_valid,
    output logic                   req_ready,
    // Routed stream out
    output request_type            out_req,
    output logic [PORTS-1:0]       out_valid,
    input  wire logic [PORTS-1:0]  tx_busy,
    // Slave discovery reports
    input  wire logic              seen_valid,
    input  wire logic [7:0]        seen_id,
    input  wire logic [1:0]        seen_port,
    // Exception and interrupt
    output logic                   drop_exc,
    output logic                   irq,
    // Pins
    input  wire logic [PORTS-1:0]  cts_pin,
    output logic [PORTS-1:0]       rts_pin
);
    // ****************************************
    // Registers
    // ****************************************
    logic          auto_q;
    logic          exc_en_q;
    logic [3:0]    status_q;
    logic [3:0]    mask_q;
    logic [7:0]    sel_q;
    port_cfg_type  cfg_q [PORTS];
    logic [48:0]   match_q [PORTS];
    logic [PORTS-1:0] busy_m_q;
    logic [PORTS-1:0] busy_q;
    logic [PORTS-1:0] baud_ok;
    logic [PORTS-1:0] tx_go;
    logic [3:0]    masters_q [PORTS];
    entry_type     table_q [IDS];
    logic [7:0]    learned_q;

    // ****************************************
    // Routing decision
    // ****************************************
    entry_type     hit;
    logic          port_hit;
    logic [1:0]    port_sel;
    logic          route_ok;
    logic          drop;
    logic          accept;
    logic          ev_conflict;
    logic          ev_learn;

    assign hit = table_q[req.slave_id];

    always_comb begin
        port_hit = 1'b0;
        port_sel = 2'h0;
        for (int p = 0; p < PORTS; p++) begin
            if (match_q[p][48] &&
                (match_q[p][47] ? req.dest_ip == match_q[p][31:0]
                                : req.tcp_port == match_q[p][47:32]) &&
                !port_hit) begin
                port_hit = 1'b1;
                port_sel = 2'(p);
            end
        end
        if (!port_hit)
            port_sel = hit.port;
    end

    assign route_ok = port_hit ? (masters_q[port_sel][req.master] ||
                                  $countones(masters_q[port_sel]) <
                                  `MASTERS_MAX)
                               : hit.valid && !hit.conflict;
    assign drop = req_valid && (!route_ok ||
                  req.queue_fill >= 5'(`QUEUE_DEPTH - 1));
    assign req_ready = !busy_q[port_sel] || drop;
    assign accept = req_valid && req_ready && !drop;
    assign drop_exc = drop && exc_en_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            out_req   <= '0;
            out_valid <= '0;
        end else begin
            out_valid <= '0;
            if (accept) begin
                out_req <= req;
                out_req.slave_id <= port_hit ? req.slave_id :
                                    req.slave_id + hit.offset;
                out_valid[port_sel] <= tx_go[port_sel] || 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            busy_m_q <= '0;
            busy_q   <= '0;
        end else begin
            busy_m_q <= tx_busy;
            busy_q   <= busy_m_q;
        end
    end

    // Masters sharing each port under port routing
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int p = 0; p < PORTS; p++)
                masters_q[p] <= 4'h0;
        end else if (accept && port_hit) begin
            masters_q[port_sel][req.master] <= 1'b1;
        end
    end

    // ****************************************
    // Slave ID table with learning
    // ****************************************
    logic      tbl_wr;
    entry_type seen_e;
    assign tbl_wr = reg_write && reg_addr == `OFF_TABLE_DATA;
    assign seen_e = table_q[seen_id];
    assign ev_learn = seen_valid && auto_q && !seen_e.user &&
                      !seen_e.valid;
    assign ev_conflict = seen_valid && auto_q && !seen_e.user &&
                         seen_e.valid && seen_e.port != seen_port;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < IDS; i++) begin
                table_q[i] <= '0;
                if (8'(i) >= `DEF_LO_ID && 8'(i) <= `DEF_HI_ID) begin
                    table_q[i].valid <= 1'b1;
                    table_q[i].user  <= 1'b1;
                    table_q[i].port  <= (8'(i) > `DEF_MID_ID) ? 2'h1 : 2'h0;
                end
            end
            learned_q <= 8'h0;
        end else begin
            if (reg_write && reg_addr == `OFF_CTRL &&
                reg_wdata[`CTRL_AUTO_BIT] && reg_wdata[8]) begin
                for (int i = 0; i < IDS; i++)
                    table_q[i] <= '0;
            end else if (tbl_wr) begin
                table_q[sel_q] <= entry_type'(reg_wdata[12:0]);
            end
            if (ev_learn) begin
                table_q[seen_id].valid <= 1'b1;
                table_q[seen_id].port  <= seen_port;
                table_q[seen_id].offset <= 8'h0;
                learned_q <= seen_id;
            end else if (ev_conflict) begin
                table_q[seen_id].conflict <= 1'b1;
            end
        end
    end

    // ****************************************
    // Serial ports
    // ****************************************
    for (genvar g = 0; g < PORTS; g++) begin : g_port
        serial_port_ctrl #(
            .MS_CYCLES (MS_CYCLES)
        ) u_port (
            .clk     (clk),
            .reset_n (reset_n),
            .cfg     (cfg_q[g]),
            .tx_req  (out_valid[g] || busy_q[g]),
            .tx_busy (busy_q[g]),
            .tx_go   (tx_go[g]),
            .cts_pin (cts_pin[g]),
            .rts_pin (rts_pin[g]),
            .baud_ok (baud_ok[g])
        );
    end

    // ****************************************
    // Register writes
    // ****************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            auto_q   <= 1'b0;
            exc_en_q <= 1'b0;
            mask_q   <= 4'h0;
            sel_q    <= 8'h0;
            for (int p = 0; p < PORTS; p++) begin
                cfg_q[p]   <= '0;
                match_q[p] <= '0;
            end
        end else if (reg_write) begin
            if (reg_addr == `OFF_CTRL) begin
                auto_q   <= reg_wdata[`CTRL_AUTO_BIT];
                exc_en_q <= reg_wdata[`CTRL_EXC_BIT];
            end
            if (reg_addr == `OFF_MASK)
                mask_q <= reg_wdata[3:0];
            if (reg_addr == `OFF_TABLE_SEL)
                sel_q <= reg_wdata[7:0];
            for (int p = 0; p < PORTS; p++) begin
                if (reg_addr == `OFF_PORT_CFG0 + 8'(4 * p))
                    cfg_q[p][20:0] <= reg_wdata[20:0];
                if (reg_addr == `OFF_BAUD0 + 8'(4 * p))
                    cfg_q[p].baud <= reg_wdata[19:0];
                if (reg_addr == `OFF_MATCH0 + 8'(8 * p))
                    match_q[p][31:0] <= reg_wdata;
                if (reg_addr == `OFF_MATCH0 + 8'(8 * p + 4))
                    match_q[p][48:32] <= reg_wdata[16:0];
            end
        end
    end

    // ****************************************
    // Status, interrupt and reads
    // ****************************************
    logic [3:0] events;
    logic       st_rd;
    assign events = {accept, ev_learn, ev_conflict, drop};
    assign st_rd  = reg_read && reg_addr == `OFF_STATUS;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            status_q <= 4'h0;
        else
            status_q <= (st_rd ? 4'h0 : status_q) | events;
    end
    assign irq = |(status_q & mask_q);

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_read) begin
            reg_rdata <= `OFF_UNMAPPED;
            if (reg_addr == `OFF_CTRL)
                reg_rdata <= {30'h0, exc_en_q, auto_q};
            if (reg_addr == `OFF_STATUS)
                reg_rdata <= {20'h0, baud_ok[3:0] & {4{PORTS >= 4}},
                              4'h0, status_q};
            if (reg_addr == `OFF_MASK)
                reg_rdata <= {28'h0, mask_q};
            if (reg_addr == `OFF_TABLE_SEL)
                reg_rdata <= {24'h0, sel_q};
            if (reg_addr == `OFF_TABLE_DATA)
                reg_rdata <= {19'h0, table_q[sel_q]};
            if (reg_addr == `OFF_LEARN)
                reg_rdata <= {24'h0, learned_q};
            for (int p = 0; p < PORTS; p++) begin
                if (reg_addr == `OFF_PORT_CFG0 + 8'(4 * p))
                    reg_rdata <= {11'h0, cfg_q[p][20:0]};
                if (reg_addr == `OFF_MATCH0 + 8'(8 * p))
                    reg_rdata <= match_q[p][31:0];
                if (reg_addr == `OFF_MATCH0 + 8'(8 * p + 4))
                    reg_rdata <= {15'h0, match_q[p][48:32]};
            end
        end else begin
            reg_rdata <= 32'h0;
        end
    end
endmodule : request_router

// ==== design/router_consts.svh ====
// Constants of the request port router: offsets, fields, reset values, times
// Included by the router, port controller, checker and bench; no code in here
`ifndef ROUTER_CONSTS_SVH
`define ROUTER_CONSTS_SVH
`define OFF_CTRL        8'h00
`define OFF_STATUS      8'h04
`define OFF_MASK        8'h08
`define OFF_TABLE_SEL   8'h0c
`define OFF_TABLE_DATA  8'h10
`define OFF_PORT_CFG0   8'h20
`define OFF_BAUD0       8'h30
`define OFF_MATCH0      8'h40
`define OFF_LEARN       8'h60
`define OFF_UNMAPPED    32'h0000_0000
`define CTRL_AUTO_BIT   0
`define CTRL_EXC_BIT    1
`define ST_DROP_BIT     0
`define ST_CONFLICT_BIT 1
`define ST_LEARN_BIT    2
`define ST_FWD_BIT      3
`define DEF_LO_ID       8'h01
`define DEF_MID_ID      8'h05
`define DEF_HI_ID       8'h0a
`define RTS_MAX_MS      100
`define CLK_HZ          50000000
`define RTS_MS_CYCLES   ((`CLK_HZ) / 1000)
`define BAUD_MIN        50
`define BAUD_MAX        961200
`define QUEUE_DEPTH     32
`define MASTERS_MAX     4
`endif

// ==== design/router_pkg.sv ====
// Types shared by the request port router and its serial port controller
// Assumes router_consts.svh is on the include path
package router_pkg;
    typedef enum logic [2:0] {
        par_none, par_odd, par_even, par_space, par_mark
    } parity_type;
    typedef enum logic [1:0] {
        flow_none, flow_rtscts, flow_toggle
    } flow_type;
    typedef struct packed {
        logic [19:0] baud;
        parity_type  parity;
        logic        two_stop;
        flow_type    flow;
        logic        rs232;
        logic [6:0]  on_ms;
        logic [6:0]  off_ms;
    } port_cfg_type;
    typedef struct packed {
        logic       valid;
        logic       user;
        logic       conflict;
        logic [1:0] port;
        logic [7:0] offset;
    } entry_type;
    typedef struct packed {
        logic [7:0]  slave_id;
        logic [15:0] tcp_port;
        logic [31:0] dest_ip;
        logic [1:0]  master;
        logic [4:0]  queue_fill;
        logic        last;
        logic [7:0]  data;
    } request_type;
endpackage : router_pkg

// ==== design/serial_port_ctrl.sv ====
// Serial port controller: bit-rate status and RTS direction control
// Assumes a character transmitter beside it that reports tx_busy
`timescale 1ns/10ps
`include "router_consts.svh"
module serial_port_ctrl
    import router_pkg::*;
#(
    parameter int MS_CYCLES = `RTS_MS_CYCLES
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         reset_n,
    // Configuration
    input  wire port_cfg_type cfg,
    // Transmit side
    input  wire logic         tx_req,
    input  wire logic         tx_busy,
    output logic              tx_go,
    // Pins
    input  wire logic         cts_pin,
    output logic              rts_pin,
    // Status
    output logic              baud_ok
);
    // ****************************************
    // RTS sequencing
    // ****************************************
    typedef enum logic [1:0] {idle, on_wait, sending, off_wait} rts_state_type;
    rts_state_type state_q;
    logic [22:0]   cnt_q;
    logic [6:0]    ms_q;
    logic          cts_m_q;
    logic          cts_q;
    logic          toggle;
    assign toggle = (cfg.flow == flow_toggle) && cfg.rs232;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cts_m_q <= 1'b0;
            cts_q   <= 1'b0;
        end else begin
            cts_m_q <= cts_pin;
            cts_q   <= cts_m_q;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= idle;
            cnt_q   <= 23'h0;
            ms_q    <= 7'h0;
        end else begin
            unique case (state_q)
                idle: if (tx_req && toggle) begin
                    state_q <= (cfg.on_ms == 7'h0) ? sending : on_wait;
                    ms_q    <= cfg.on_ms;
                    cnt_q   <= 23'h0;
                end
                on_wait, off_wait: begin
                    if (cnt_q == 23'(MS_CYCLES - 1)) begin
                        cnt_q <= 23'h0;
                        ms_q  <= ms_q - 7'h1;
                        if (ms_q == 7'h1)
                            state_q <= (state_q == on_wait) ? sending : idle;
                    end else begin
                        cnt_q <= cnt_q + 23'h1;
                    end
                end
                sending: if (!tx_req && !tx_busy) begin
                    state_q <= (cfg.off_ms == 7'h0) ? idle : off_wait;
                    ms_q    <= cfg.off_ms;
                    cnt_q   <= 23'h0;
                end
            endcase
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    always_comb begin
        unique case (cfg.flow)
            flow_toggle: rts_pin = toggle && (state_q != idle);
            flow_rtscts: rts_pin = 1'b1;
            default:     rts_pin = 1'b0;
        endcase
    end
    assign tx_go = tx_req && (toggle ? state_q == sending :
                   cfg.flow == flow_rtscts ? cts_q : 1'b1);
    assign baud_ok = (cfg.baud >= 20'(`BAUD_MIN)) &&
                     (cfg.baud <= 20'(`BAUD_MAX));
endmodule : serial_port_ctrl

// ==== sim/router_assertions.sv ====
// Checker for the request port router, watching its top-level ports only
// Assumes router_consts.svh on the include path; bound after the module
`timescale 1ns/10ps
`include "router_consts.svh"
module router_checker
    import router_pkg::*;
#(
    parameter int PORTS = 4
) (
    // Clock and reset
    input wire logic             clk,
    input wire logic             reset_n,
    // Register port
    input wire logic [7:0]       reg_addr,
    input wire logic [31:0]      reg_wdata,
    input wire logic             reg_write,
    input wire logic             reg_read,
    input wire logic [31:0]      reg_rdata,
    // Streams
    input wire request_type      req,
    input wire logic             req_valid,
    input wire logic             req_ready,
    input wire request_type      out_req,
    input wire logic [PORTS-1:0] out_valid,
    // Exception and interrupt
    input wire logic             drop_exc,
    input wire logic             irq
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    valid_onehot_a: assert property ($onehot0(out_valid))
        else $error("request sent to more than one port");
    valid_cause_a: assert property (out_valid != 0 |->
        $past(req_valid && req_ready))
        else $error("output without accepted request");
    drop_silent_a: assert property (drop_exc |=> out_valid == 0)
        else $error("dropped request still forwarded");
    queue_full_a: assert property (req_valid && req_ready &&
        req.queue_fill >= 5'h1f |=> out_valid == 0)
        else $error("request forwarded with full queue");
    data_pass_a: assert property (out_valid != 0 |->
        out_req.data == $past(req.data) && out_req.last == $past(req.last))
        else $error("payload changed on the way");
    tcp_pass_a: assert property (out_valid != 0 |->
        out_req.tcp_port == $past(req.tcp_port))
        else $error("tcp port changed on the way");
    exc_cause_a: assert property (drop_exc |-> req_valid)
        else $error("exception without request");
    mask_off_a: assert property (reg_write && reg_addr == `OFF_MASK &&
        reg_wdata == 32'h0 |=> !irq)
        else $error("interrupt with everything masked");
endmodule : router_checker

bind request_router router_checker #(.PORTS(PORTS)) chk (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .out_req(out_req), .out_valid(out_valid),
    .drop_exc(drop_exc), .irq(irq)
);

// ==== sim/slave_model.sv ====
// Serial slaves behind the ports: busy while answering, discovery reports
// Assumes one out_valid pulse per request; busy length set by the bench
`timescale 1ns/10ps
module slave_model (
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // Routed requests
    input wire logic [3:0]  out_valid,
    input wire logic [3:0]  busy_len,
    output logic [3:0]      tx_busy,
    // Discovery
    output logic            seen_valid,
    output logic [7:0]      seen_id,
    output logic [1:0]      seen_port
);
    logic [3:0] cnt_q [4];
    initial begin
        seen_valid = 1'b0;
        seen_id    = 8'h00;
        seen_port  = 2'h0;
    end
    // Each port stays busy for busy_len cycles after a request
    always_ff @(posedge clk or negedge reset_n) begin
        for (int p = 0; p < 4; p++) begin
            if (!reset_n)
                cnt_q[p] <= 4'h0;
            else if (out_valid[p])
                cnt_q[p] <= busy_len;
            else if (cnt_q[p] != 0)
                cnt_q[p] <= cnt_q[p] - 4'h1;
        end
    end
    always_comb begin
        for (int p = 0; p < 4; p++)
            tx_busy[p] = cnt_q[p] != 0;
    end
    // A slave answers from a port, one pulse
    task automatic announce(input logic [7:0] id, input logic [1:0] port);
        @(posedge clk);
        seen_valid <= 1'b1;
        seen_id    <= id;
        seen_port  <= port;
        @(posedge clk);
        seen_valid <= 1'b0;
        seen_id    <= ~id;
        seen_port  <= ~port;
    endtask : announce
endmodule : slave_model

// ==== sim/testbench.sv ====
// Self-checking bench of the request port router
// Assumes the checker is bound and the slave model stands behind the ports
`timescale 1ns/10ps
`include "router_consts.svh"
module testbench;
    import router_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, reg_write = 1'b0, reg_read = 1'b0;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, rnd = 32'h42;
    request_type req = '0, out_req;
    logic        req_valid = 1'b0, req_ready, drop_exc, irq, seen_valid;
    logic [3:0]  out_valid, tx_busy, rts_pin, busy_len = 4'h3;
    logic [7:0]  seen_id;
    logic [1:0]  seen_port;
    logic [9:0]  exp_out[$];
    logic [63:0] exp_rd[$];
    logic        rd_flag = 1'b0;
    int mismatches = 0, comparisons = 0;

    always #10 clk = ~clk;
    request_router #(.PORTS(4), .IDS(256), .MS_CYCLES(4)) uut (
        .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .req(req), .req_valid(req_valid),
        .req_ready(req_ready), .out_req(out_req), .out_valid(out_valid),
        .tx_busy(tx_busy), .seen_valid(seen_valid), .seen_id(seen_id),
        .seen_port(seen_port), .drop_exc(drop_exc), .irq(irq),
        .cts_pin(4'h0), .rts_pin(rts_pin));
    slave_model partner (.clk(clk), .reset_n(reset_n),
        .out_valid(out_valid), .busy_len(busy_len), .tx_busy(tx_busy),
        .seen_valid(seen_valid), .seen_id(seen_id), .seen_port(seen_port));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] expd);
        comparisons++;
        if (seen !== expd) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, expd, seen);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d, mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a; reg_wdata <= d; reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m);
        @(posedge clk);
        reg_addr <= a; reg_read <= 1'b1;
        exp_rd.push_back({e, m});
        @(posedge clk);
        reg_read <= 1'b0;
    endtask : rd
    // One request; port 3'h4 in exp_port means a drop is expected
    task automatic send(input logic [7:0] id, input logic [15:0] tcp,
        input logic [31:0] ip, input logic [4:0] fill,
        input logic [2:0] exp_port, input logic [7:0] exp_id);
        int n;
        rnd = xs(rnd);
        @(posedge clk);
        req <= '{slave_id: id, tcp_port: tcp, dest_ip: ip,
                 master: rnd[9:8], queue_fill: fill, last: rnd[10],
                 data: rnd[7:0]};
        req_valid <= 1'b1;
        n = 0;
        #1;
        while (req_ready !== 1'b1 && n < 200) begin
            @(posedge clk); #1;
            n++;
        end
        if (n == 200) begin
            mismatches++;
            test_done();
        end
        check("drop_exc", drop_exc, exp_port[2]);
        if (!exp_port[2])
            exp_out.push_back({exp_port[1:0], exp_id});
        @(posedge clk);
        req_valid <= 1'b0;
    endtask : send

    // ************************************************************
    // Output monitor
    // ************************************************************
    always @(posedge clk) begin
        logic [9:0]  e;
        logic [63:0] r;
        #1;
        if (rd_flag) begin
            r = exp_rd.pop_front();
            check("reg_rdata", reg_rdata & r[31:0], r[63:32]);
        end
        rd_flag = reg_read;
        if (out_valid !== 4'h0) begin
            if (exp_out.size() == 0) begin
                check("spare out_valid", {28'h0, out_valid}, 32'h0);
            end else begin
                e = exp_out.pop_front();
                check("out_valid", out_valid, 4'h1 << e[9:8]);
                check("slave_id", out_req.slave_id, e[7:0]);
            end
        end
    end
    initial begin
        #1_900_000;
        mismatches++;
        test_done();
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        rd(`OFF_MASK, 32'h0, 32'hffff_ffff);
        rd(8'hfc, 32'h0, 32'hffff_ffff);
        wr(`OFF_CTRL, 32'h2);
        wr(`OFF_BAUD0, 32'h2580);
        rd(`OFF_STATUS, 32'h100, 32'h300);
        $display("test registers done");
        for (int i = 1; i <= 10; i++)
            send(i, 16'h1, 32'h1, 5'd0, i <= 5 ? 3'd0 : 3'd1, i);
        busy_len <= 4'hf;
        for (int i = 1; i <= 3; i++)
            send(i, 16'h1, 32'h1, 5'd30, 3'd0, i);
        busy_len <= 4'h2;
        $display("test default table done");
        wr(`OFF_TABLE_SEL, 32'h2);
        wr(`OFF_TABLE_DATA, 32'h19ff);
        send(8'h2, 16'h1, 32'h1, 5'd0, 3'd1, 8'h1);
        $display("test offset done");
        wr(8'h4c, 32'h1_07d1);
        send(8'h1, 16'd2001, 32'h1, 5'd0, 3'd1, 8'h1);
        wr(8'h4c, 32'h0);
        wr(8'h50, 32'hc0a8_0101);
        wr(8'h54, 32'h1_8000);
        send(8'h1, 16'h1, 32'hc0a8_0101, 5'd0, 3'd2, 8'h1);
        wr(8'h54, 32'h0);
        $display("test port routing done");
        rd(`OFF_STATUS, 32'h0, 32'h1);
        wr(`OFF_MASK, 32'h1);
        send(8'd200, 16'h1, 32'h1, 5'd0, 3'h4, 8'h0);
        send(8'h3, 16'h1, 32'h1, 5'd31, 3'h4, 8'h0);
        check("irq", irq, 1'b1);
        rd(`OFF_STATUS, 32'h1, 32'h1);
        #1;
        check("irq", irq, 1'b0);
        rd(`OFF_STATUS, 32'h0, 32'h1);
        wr(`OFF_MASK, 32'h0);
        $display("test drops done");
        wr(`OFF_CTRL, 32'h103);
        wr(`OFF_CTRL, 32'h3);
        send(8'h1, 16'h1, 32'h1, 5'd0, 3'h4, 8'h0);
        partner.announce(8'd20, 2'd2);
        repeat (3) @(posedge clk);
        send(8'd20, 16'h1, 32'h1, 5'd0, 3'd2, 8'd20);
        partner.announce(8'd21, 2'd3);
        repeat (3) @(posedge clk);
        send(8'd21, 16'h1, 32'h1, 5'd0, 3'd3, 8'd21);
        wr(`OFF_TABLE_SEL, 32'd30);
        wr(`OFF_TABLE_DATA, 32'h1800);
        partner.announce(8'd30, 2'd3);
        repeat (3) @(posedge clk);
        send(8'd30, 16'h1, 32'h1, 5'd0, 3'd0, 8'd30);
        rd(`OFF_STATUS, 32'h0, 32'h2);
        partner.announce(8'd20, 2'd3);
        repeat (3) @(posedge clk);
        rd(`OFF_STATUS, 32'h2, 32'h2);
        send(8'd20, 16'h1, 32'h1, 5'd0, 3'h4, 8'h0);
        $display("test learning done");
        wr(`OFF_PORT_CFG0, 32'h1_4081);
        send(8'd30, 16'h1, 32'h1, 5'd0, 3'd0, 8'd30);
        repeat (2) @(posedge clk);
        #1 check("rts_pin", rts_pin[0], 1'b1);
        repeat (20) @(posedge clk);
        #1 check("rts_pin", rts_pin[0], 1'b0);
        $display("test rts toggle done");
        repeat (30) @(posedge clk);
        check("pending outputs", exp_out.size(), 32'h0);
        test_done();
    end
endmodule : testbench
